// >>> bench/rsc_far_end.sv
`timescale 1ns/1ps
module rsc_far_end (
   input logic ref_clk,
   output logic ext_reset_pin_n,
   output logic supply_below_por,
   output logic [2:0] volt_mon_below,
   output logic battery_switch_det,
   output logic indep_wdog_underflow,
   output logic sys_wdog_expire,
   output rsc_pkg::rsc_fault_s fault_req
);
   import rsc_pkg::*;
   // ---------------------------------------------
   // event sources: b0 indep wdog, b1 sys wdog,
   // b2 battery switch, b9:3 fault detectors
   // ---------------------------------------------
   logic [9:0] ev = 10'h0;
   assign indep_wdog_underflow = ev[0];
   assign sys_wdog_expire = ev[1];
   assign battery_switch_det = ev[2];
   assign fault_req = ev[9:3];
   task automatic level(input logic pin, input logic sup,
                        input logic [2:0] vm);
      ext_reset_pin_n = pin;
      supply_below_por = sup;
      volt_mon_below = vm;
   endtask
   // one-cycle report, launched just after an edge
   task automatic pulse(input logic [9:0] v);
      ev = v;
      @(posedge ref_clk);
      #1;
      ev = 10'h0;
   endtask
   initial level(1'b1, 1'b0, 3'h0);
endmodule

// >>> bench/rsc_reset_source_controller_properties.sv
`timescale 1ns/1ps
module rsc_checker (
   input logic ref_clk,
   input logic rstn,
   input logic ext_reset_pin_n,
   input logic supply_below_por,
   input logic indep_wdog_underflow,
   input logic indep_wdog_reset_mode,
   input logic sys_wdog_expire,
   input logic sys_wdog_reset_mode,
   input logic deep_standby_cancel,
   input logic core_sw_reset_request,
   input rsc_pkg::rsc_fault_s fault_req,
   input logic cold_warm_write,
   input logic cold_warm_wdata,
   input logic sys_reset_n,
   input logic osc_restart,
   input logic nmi_req,
   input logic [7:0] reset_status_0,
   input logic [15:0] reset_status_1,
   input logic [7:0] reset_status_2
);
   import rsc_pkg::*;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   a_pin_forces_reset: assert property (
      !ext_reset_pin_n |-> ##2 !sys_reset_n)
      else $error("pin low did not reset chip");
   a_por_reasserts: assert property (
      supply_below_por && ext_reset_pin_n |-> ##2 !sys_reset_n)
      else $error("low supply did not reset chip");
   a_indep_wdog_flag: assert property (
      indep_wdog_underflow && indep_wdog_reset_mode
      |=> reset_status_1[S1_INDEP_WDOG] ##1 !sys_reset_n)
      else $error("indep wdog reset missing");
   a_sys_wdog_nmi: assert property (
      sys_wdog_expire && !sys_wdog_reset_mode |=> nmi_req)
      else $error("sys wdog nmi missing");
   a_sw_flag_reset: assert property (
      core_sw_reset_request
      |=> reset_status_1[S1_SW] ##1 (!sys_reset_n) [*8])
      else $error("sw reset flag or reset missing");
   a_sw_hold_time: assert property (
      core_sw_reset_request |-> ##38 !sys_reset_n)
      else $error("sw reset released early");
   a_dsby_osc_flag: assert property (
      deep_standby_cancel |=> osc_restart && reset_status_0[S0_DSBY])
      else $error("deep standby restart or flag missing");
   a_dsby_hold_wait: assert property (
      deep_standby_cancel |-> ##34 !sys_reset_n)
      else $error("deep standby reset released early");
   a_fault_flag_reset: assert property (
      fault_req.sram_ecc
      |=> reset_status_1[S1_SRAM_ECC] ##1 !sys_reset_n)
      else $error("ecc fault reset missing");
   a_cold_set_write: assert property (
      cold_warm_write && cold_warm_wdata |=> reset_status_2[0])
      else $error("cold warm flag not set");
   a_cold_kept_warm: assert property (
      reset_status_2[0] && !supply_below_por |=> reset_status_2[0])
      else $error("cold warm flag lost");
   cover property (deep_standby_cancel ##2 !sys_reset_n);
   cover property (core_sw_reset_request ##2 !sys_reset_n);
   cover property ($rose(sys_reset_n));
endmodule
bind rsc_reset_source_controller rsc_checker chk (.*);

// >>> bench/tb_reset_source_controller.sv
`timescale 1ns/1ps
module tb_reset_source_controller;
   import rsc_pkg::*;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic ext_reset_pin_n, supply_below_por, battery_switch_det;
   logic indep_wdog_underflow, sys_wdog_expire;
   logic [2:0] volt_mon_below;
   rsc_fault_s fault_req;
   logic indep_wdog_reset_mode = 1'b1;
   logic sys_wdog_reset_mode = 1'b1;
   rsc_vmon_cfg_s option_setting_1 = '0;
   logic option_load = 1'b0;
   logic deep_standby_cancel = 1'b0;
   logic core_sw_reset_request = 1'b0;
   logic cold_warm_write = 1'b0;
   logic cold_warm_wdata = 1'b0;
   logic sys_reset_n, osc_restart, nmi_req;
   logic [2:0] volt_mon_irq;
   logic [7:0] reset_status_0, reset_status_2;
   logic [15:0] reset_status_1;
   logic alt_sys_reset_n;
   logic [15:0] alt_reset_status_1;
   int num_errors = 0;
   int num_checks = 0;
   int cyc = 0;
   rsc_reset_source_controller #(.POR_HOLD(10), .VMON_STAB(5)) dut (.*);
   rsc_far_end far (.*);
   // second core variant: reaches the sources only it accepts
   rsc_reset_source_controller #(.VARIANT(VARIANT_B), .POR_HOLD(10),
                                 .VMON_STAB(5)) dut_alt (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .ext_reset_pin_n(ext_reset_pin_n),
      .supply_below_por(supply_below_por),
      .volt_mon_below(volt_mon_below),
      .battery_switch_det(battery_switch_det),
      .indep_wdog_underflow(indep_wdog_underflow),
      .indep_wdog_reset_mode(indep_wdog_reset_mode),
      .sys_wdog_expire(sys_wdog_expire),
      .sys_wdog_reset_mode(sys_wdog_reset_mode),
      .option_setting_1(option_setting_1),
      .option_load(option_load),
      .deep_standby_cancel(deep_standby_cancel),
      .core_sw_reset_request(core_sw_reset_request),
      .fault_req(fault_req),
      .cold_warm_write(cold_warm_write),
      .cold_warm_wdata(cold_warm_wdata),
      .sys_reset_n(alt_sys_reset_n),
      .osc_restart(),
      .nmi_req(),
      .volt_mon_irq(),
      .reset_status_0(),
      .reset_status_1(alt_reset_status_1),
      .reset_status_2()
   );
   always #2.5 ref_clk = ~ref_clk;
   // ---------------------------------------------
   // shared drivers and compares
   // ---------------------------------------------
   task automatic tick(input int n = 1);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic strobe(ref logic s);
      s = 1'b1;
      tick();
      s = 1'b0;
   endtask
   task automatic chk(input string what, input logic [15:0] exp,
                      input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // bounded wait for release; the length must land in the window
   task automatic rel(input string what, input int lo, input int hi);
      int n;
      n = 0;
      while (sys_reset_n !== 1'b1 && n < 500) begin
         tick();
         n++;
      end
      chk(what, 16'h1, 16'((n >= lo) && (n <= hi)));
   endtask
   task automatic results();
      if (num_errors == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task automatic t_por();
      chk("rst_sys", 16'h0, 16'(sys_reset_n));
      chk("rst_st0", 16'h1, 16'(reset_status_0));
      rstn = 1'b1;
      rel("por_len", 8, 16);
      chk("rst_st1", 16'h0, reset_status_1);
      chk("rst_st2", 16'h0, 16'(reset_status_2));
   endtask
   task automatic t_sw();
      strobe(core_sw_reset_request);
      chk("sw_flag", 16'h1, 16'(reset_status_1[S1_SW]));
      rel("sw_len", 38, 46);
   endtask
   task automatic t_wdog();
      for (int k = 0; k < 2; k++) begin
         indep_wdog_reset_mode = 1'b0;
         sys_wdog_reset_mode = 1'b0;
         far.pulse(10'(1 << k));
         chk("wd_nmi", 16'h1, 16'(nmi_req));
         tick(4);
         chk("wd_run", 16'h1, 16'(sys_reset_n));
         chk("wd_noflag", 16'h0, 16'(reset_status_1[k]));
         indep_wdog_reset_mode = 1'b1;
         sys_wdog_reset_mode = 1'b1;
         far.pulse(10'(1 << k));
         chk("wd_flag", 16'h1, 16'(reset_status_1[k]));
         rel("wd_len", 18, 27);
      end
   endtask
   task automatic t_faults();
      for (int k = 0; k < 5; k++) begin
         far.pulse({7'(7'h40 >> k), 3'h0});
         chk("flt_flag", 16'h1, 16'(reset_status_1[S1_SRAM_PAR + k]));
         rel("flt_len", 18, 27);
      end
      far.pulse(10'h4);
      chk("batt_flag", 16'h1, 16'(reset_status_1[S1_BATT]));
      rel("batt_len", 18, 27);
      far.pulse(10'h18);
      chk("alt_sec", 16'h1, 16'(alt_reset_status_1[S1_SEC]));
      chk("alt_cpar", 16'h1, 16'(alt_reset_status_1[S1_CACHE]));
      chk("alt_rst", 16'h0, 16'(alt_sys_reset_n));
      chk("flt_a_sec", 16'h0, 16'(reset_status_1[S1_SEC]));
      chk("flt_a_cpar", 16'h0, 16'(reset_status_1[S1_CACHE]));
      tick(24);
      chk("flt_a_run", 16'h1, 16'(sys_reset_n));
      chk("alt_len", 16'h1, 16'(alt_sys_reset_n));
   endtask
   task automatic t_dsby();
      strobe(deep_standby_cancel);
      chk("osc", 16'h1, 16'(osc_restart));
      chk("ds_flag", 16'h1, 16'(reset_status_0[S0_DSBY]));
      rel("ds_len", 33, 40);
   endtask
   task automatic t_vmon();
      far.level(1'b1, 1'b0, 3'h7);
      tick(6);
      chk("vm_off", 16'h8, 16'({sys_reset_n, volt_mon_irq}));
      far.level(1'b1, 1'b0, 3'h0);
      option_setting_1 = '{enable: 3'h7, reset_mode: 3'h1};
      strobe(option_load);
      far.level(1'b1, 1'b0, 3'h2);
      tick(3);
      chk("vm_irq", 16'ha, 16'({sys_reset_n, volt_mon_irq}));
      far.level(1'b1, 1'b0, 3'h0);
      option_setting_1 = '{enable: 3'h7, reset_mode: 3'h7};
      strobe(option_load);
      for (int n = 0; n < 3; n++) begin
         far.level(1'b1, 1'b0, 3'(1 << n));
         tick(20);
         chk("vm_rst", 16'h0, 16'(sys_reset_n));
         chk("vm_flag", 16'h1, 16'(reset_status_0[S0_VMON0 + n]));
         far.level(1'b1, 1'b0, 3'h0);
         rel("vm_len", 4, 11);
      end
   endtask
   task automatic t_cold();
      cold_warm_wdata = 1'b1;
      strobe(cold_warm_write);
      chk("cw_set", 16'h1, 16'(reset_status_2[0]));
      tick();
      cold_warm_wdata = 1'b0;
      strobe(cold_warm_write);
      chk("cw_keep", 16'h1, 16'(reset_status_2[0]));
      far.level(1'b0, 1'b0, 3'h0);
      tick(6);
      chk("pin_rst", 16'h0, 16'(sys_reset_n));
      far.level(1'b1, 1'b0, 3'h0);
      rel("pin_len", 0, 12);
      chk("pin_power_on_flag", 16'h0, 16'(reset_status_0[S0_POR]));
      chk("cw_warm", 16'h1, 16'(reset_status_2[0]));
      far.level(1'b1, 1'b1, 3'h0);
      tick(30);
      chk("por_low", 16'h0, 16'(sys_reset_n));
      far.level(1'b1, 1'b0, 3'h0);
      rel("por_len2", 8, 16);
      chk("cw_cold", 16'h0, 16'(reset_status_2[0]));
      chk("por_flag", 16'h1, 16'(reset_status_0[S0_POR]));
      far.level(1'b1, 1'b0, 3'h1);
      tick(4);
      chk("vm_off2", 16'h1, 16'(sys_reset_n));
      far.level(1'b1, 1'b0, 3'h0);
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 2000) begin
         num_errors++;
         results();
      end
   end
   initial begin
      tick(8);
      t_por();
      t_sw();
      t_wdog();
      t_faults();
      t_dsby();
      t_vmon();
      t_cold();
      results();
   end
endmodule

// >>> design/rsc_pkg.sv
package rsc_pkg;
   // ------------------------------------------------------------
   // core variants
   // ------------------------------------------------------------
   localparam int VARIANT_A = 0;
   localparam int VARIANT_B = 1;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int POR_HOLD_US = 1000;
   localparam int VMON_STAB_US = 100;
   localparam int WDOG_DELAY_NS = 100;
   localparam int SW_RELEASE_NS = 200;
   localparam int DSBY_WAIT_CYC = 35;
   localparam int POR_HOLD_CYC = POR_HOLD_US * CLK_MHZ;
   localparam int VMON_STAB_CYC = VMON_STAB_US * CLK_MHZ;
   localparam int WDOG_DELAY_CYC = (WDOG_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int SW_RELEASE_CYC = (SW_RELEASE_NS * CLK_MHZ + 999) / 1000;
   localparam int CNT_W = 24;

   // ------------------------------------------------------------
   // status bit positions
   // ------------------------------------------------------------
   localparam int S0_POR = 0;
   localparam int S0_VMON0 = 1;
   localparam int S0_VMON1 = 2;
   localparam int S0_VMON2 = 3;
   localparam int S0_DSBY = 7;
   localparam int S1_INDEP_WDOG = 0;
   localparam int S1_SYS_WDOG = 1;
   localparam int S1_SW = 2;
   localparam int S1_SRAM_PAR = 8;
   localparam int S1_SRAM_ECC = 9;
   localparam int S1_BUSM = 10;
   localparam int S1_BUSS = 11;
   localparam int S1_SP = 12;
   localparam int S1_SEC = 13;
   localparam int S1_CACHE = 14;
   localparam int S1_BATT = 15;

   typedef struct packed {
      logic sram_parity;
      logic sram_ecc;
      logic bus_master;
      logic bus_slave;
      logic stack_ptr;
      logic security;
      logic cache_parity;
   } rsc_fault_s;

   typedef struct packed {
      logic [2:0] enable;
      logic [2:0] reset_mode;
   } rsc_vmon_cfg_s;

   typedef enum logic [1:0] {
      RSC_RUN,
      RSC_HOLD,
      RSC_WAIT_REL
   } rsc_state_e;
endpackage

// >>> design/rsc_reset_source_controller.sv
`timescale 1ns/1ps
module rsc_reset_source_controller #(
   parameter int VARIANT = rsc_pkg::VARIANT_A,
   parameter int HAS_CACHE_PARITY = 1,
   parameter int POR_HOLD = rsc_pkg::POR_HOLD_CYC,
   parameter int VMON_STAB = rsc_pkg::VMON_STAB_CYC
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic ext_reset_pin_n,
   input wire logic supply_below_por,
   input wire logic [2:0] volt_mon_below,
   input wire logic battery_switch_det,
   input wire logic indep_wdog_underflow,
   input wire logic indep_wdog_reset_mode,
   input wire logic sys_wdog_expire,
   input wire logic sys_wdog_reset_mode,
   input wire rsc_pkg::rsc_vmon_cfg_s option_setting_1,
   input wire logic option_load,
   input wire logic deep_standby_cancel,
   input wire logic core_sw_reset_request,
   input wire rsc_pkg::rsc_fault_s fault_req,
   input wire logic cold_warm_write,
   input wire logic cold_warm_wdata,
   output logic sys_reset_n,
   output logic osc_restart,
   output logic nmi_req,
   output logic [2:0] volt_mon_irq,
   output logic [7:0] reset_status_0,
   output logic [15:0] reset_status_1,
   output logic [7:0] reset_status_2
);
   import rsc_pkg::*;

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   // hold counters are CNT_W bits, the short and wake counters 6 bits
   if (POR_HOLD < 1 || POR_HOLD >= (1 << CNT_W)) begin : g_bad_por
      $error("power-on hold count out of range");
   end
   if (VMON_STAB < 1 || VMON_STAB >= (1 << CNT_W)) begin : g_bad_stab
      $error("stabilization count out of range");
   end
   if (WDOG_DELAY_CYC < 1 || WDOG_DELAY_CYC > 63 || SW_RELEASE_CYC < 1 ||
       SW_RELEASE_CYC > 63 || DSBY_WAIT_CYC > 63) begin : g_bad_short
      $error("short hold does not fit its counter");
   end
   if (VARIANT != VARIANT_A && VARIANT != VARIANT_B) begin : g_bad_var
      $error("unknown variant");
   end
   if (HAS_CACHE_PARITY != 0 && HAS_CACHE_PARITY != 1) begin : g_bad_cache
      $error("cache parity option must be 0 or 1");
   end

   // ------------------------------------------------------------
   // source qualification
   // ------------------------------------------------------------
   logic pin_low;
   logic batt_ok;
   logic [2:0] vmon_en;
   logic [2:0] vmon_rst_mode;
   logic [2:0] vmon_rst;
   logic wdog_i_rst;
   logic wdog_s_rst;
   logic [6:0] fault_hit;
   logic fault_any;
   logic por_active;
   logic [CNT_W-1:0] por_cnt;
   logic [CNT_W-1:0] vmon_cnt;
   logic vmon_hold;
   logic [5:0] short_cnt;
   logic short_hold;
   rsc_state_e state;

   assign pin_low = !ext_reset_pin_n;
   assign batt_ok = (VARIANT == VARIANT_A) && battery_switch_det;
   assign vmon_rst = volt_mon_below & vmon_en & vmon_rst_mode;
   assign wdog_i_rst = indep_wdog_underflow & indep_wdog_reset_mode;
   assign wdog_s_rst = sys_wdog_expire & sys_wdog_reset_mode;

   // fault detectors: no enable gates them, only the core variant and, for cache parity, HAS_CACHE_PARITY
   always_comb begin
      fault_hit = '0;
      fault_hit[0] = fault_req.sram_parity;
      fault_hit[1] = fault_req.sram_ecc;
      fault_hit[2] = fault_req.bus_master;
      if (VARIANT == VARIANT_A) begin
         fault_hit[3] = fault_req.bus_slave;
         fault_hit[4] = fault_req.stack_ptr;
      end else begin
         fault_hit[5] = fault_req.security;
         fault_hit[6] = fault_req.cache_parity && (HAS_CACHE_PARITY != 0);
      end
   end
   assign fault_any = |fault_hit;

   // ------------------------------------------------------------
   // power-on reset: held while low with the pin high, then counted out
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         por_active <= 1'b1;
         por_cnt <= '0;
      end else if (supply_below_por && ext_reset_pin_n) begin
         por_active <= 1'b1;
         por_cnt <= '0;
      end else if (por_active) begin
         if (por_cnt == CNT_W'(POR_HOLD - 1))
            por_active <= 1'b0;
         else
            por_cnt <= por_cnt + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // voltage monitor enables, cleared by power-on
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         vmon_en <= '0;
         vmon_rst_mode <= '0;
      end else if (por_active) begin
         vmon_en <= '0;
         vmon_rst_mode <= '0;
      end else if (option_load) begin
         vmon_en <= option_setting_1.enable;
         vmon_rst_mode <= option_setting_1.reset_mode;
      end
   end

   // stabilization restarts while any tripped monitor stays low
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         vmon_hold <= 1'b0;
         vmon_cnt <= '0;
      end else if (|vmon_rst) begin
         vmon_hold <= 1'b1;
         vmon_cnt <= '0;
      end else if (vmon_hold) begin
         if (vmon_cnt == CNT_W'(VMON_STAB - 1))
            vmon_hold <= 1'b0;
         else
            vmon_cnt <= vmon_cnt + 1'b1;
      end
   end

   // ------------------------------------------------------------
   // short-delay resets: watchdogs, software, faults, battery
   // ------------------------------------------------------------
   // a new event reloads the hold but never shortens what remains,
   // so a watchdog bite cannot cut a software reset short
   function automatic logic [5:0] longer(input logic [5:0] a,
                                         input logic [5:0] b);
      longer = (a > b) ? a : b;
   endfunction

   // last cycle of a hold that counts down to one
   function automatic logic last_tick(input logic [5:0] cnt);
      last_tick = (cnt <= 6'h01);
   endfunction

   logic short_evt;
   logic [5:0] short_len;
   always_comb begin
      short_evt = 1'b1;
      short_len = 6'(WDOG_DELAY_CYC);
      if (core_sw_reset_request)
         short_len = 6'(SW_RELEASE_CYC);
      else if (!(wdog_i_rst || wdog_s_rst || fault_any || batt_ok))
         short_evt = 1'b0;
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         short_hold <= 1'b0;
         short_cnt <= '0;
      end else if (short_evt) begin
         short_hold <= 1'b1;
         short_cnt <= short_hold ? longer(short_cnt, short_len) : short_len;
      end else if (short_hold) begin
         if (last_tick(short_cnt))
            short_hold <= 1'b0;
         short_cnt <= short_cnt - 6'h01;
      end
   end

   // ------------------------------------------------------------
   // deep standby cancellation wait
   // ------------------------------------------------------------
   // a counter of its own, so other events cannot shorten the wait
   logic dsby_hold;
   logic [5:0] dsby_cnt;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         dsby_hold <= 1'b0;
         dsby_cnt <= '0;
      end else if (deep_standby_cancel) begin
         dsby_hold <= 1'b1;
         dsby_cnt <= 6'(DSBY_WAIT_CYC);
      end else if (dsby_hold) begin
         if (last_tick(dsby_cnt))
            dsby_hold <= 1'b0;
         dsby_cnt <= dsby_cnt - 6'h01;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn)
         osc_restart <= 1'b0;
      else
         osc_restart <= deep_standby_cancel;
   end

   // ------------------------------------------------------------
   // system reset sequencing
   // ------------------------------------------------------------
   logic any_hold;
   assign any_hold = pin_low || por_active || vmon_hold || short_hold ||
                     dsby_hold || short_evt || deep_standby_cancel ||
                     (|vmon_rst);

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn)
         state <= RSC_HOLD;
      else begin
         case (state)
            RSC_RUN: if (any_hold) state <= RSC_HOLD;
            RSC_HOLD: if (!any_hold) state <= RSC_WAIT_REL;
            RSC_WAIT_REL: state <= any_hold ? RSC_HOLD : RSC_RUN;
            default: state <= RSC_HOLD;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn)
         sys_reset_n <= 1'b0;
      else
         sys_reset_n <= (state == RSC_WAIT_REL) && !any_hold ? 1'b1 :
                        (state == RSC_RUN) && !any_hold;
   end

   // ------------------------------------------------------------
   // interrupts instead of reset
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         nmi_req <= 1'b0;
         volt_mon_irq <= '0;
      end else begin
         nmi_req <= (indep_wdog_underflow && !indep_wdog_reset_mode) ||
                    (sys_wdog_expire && !sys_wdog_reset_mode);
         volt_mon_irq <= volt_mon_below & vmon_en & ~vmon_rst_mode;
      end
   end

   // ------------------------------------------------------------
   // status flags: rstn clears all but the POR flag, which it sets; power-on clears reset_status_1 and 2, pin reset clears the POR flag
   // ------------------------------------------------------------
   // rstn stands for the analog domain's own power-up clear;
   // in reset_status_0 a set wins over a clear in the same cycle; in 1 and 2 the power-on clear wins
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn)
         reset_status_0 <= 8'h01;
      else begin
         if (pin_low)
            reset_status_0[S0_POR] <= 1'b0;
         if (por_active)
            reset_status_0[S0_POR] <= 1'b1;
         if (vmon_rst[0])
            reset_status_0[S0_VMON0] <= 1'b1;
         if (vmon_rst[1])
            reset_status_0[S0_VMON1] <= 1'b1;
         if (vmon_rst[2])
            reset_status_0[S0_VMON2] <= 1'b1;
         if (deep_standby_cancel)
            reset_status_0[S0_DSBY] <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn)
         reset_status_1 <= 16'h0000;
      else if (por_active)
         reset_status_1 <= 16'h0000;
      else begin
         if (wdog_i_rst)
            reset_status_1[S1_INDEP_WDOG] <= 1'b1;
         if (wdog_s_rst)
            reset_status_1[S1_SYS_WDOG] <= 1'b1;
         if (core_sw_reset_request)
            reset_status_1[S1_SW] <= 1'b1;
         if (fault_hit[0])
            reset_status_1[S1_SRAM_PAR] <= 1'b1;
         if (fault_hit[1])
            reset_status_1[S1_SRAM_ECC] <= 1'b1;
         if (fault_hit[2])
            reset_status_1[S1_BUSM] <= 1'b1;
         if (fault_hit[3])
            reset_status_1[S1_BUSS] <= 1'b1;
         if (fault_hit[4])
            reset_status_1[S1_SP] <= 1'b1;
         if (fault_hit[5])
            reset_status_1[S1_SEC] <= 1'b1;
         if (fault_hit[6])
            reset_status_1[S1_CACHE] <= 1'b1;
         if (batt_ok)
            reset_status_1[S1_BATT] <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn)
         reset_status_2 <= 8'h00;
      else if (por_active)
         reset_status_2 <= 8'h00;
      else if (cold_warm_write && cold_warm_wdata)
         reset_status_2[0] <= 1'b1;
   end
endmodule
